//--- verilog/eesf_pkg.sv
// Purpose: Shared constants for the two-wire memory slave front end and its master
// Assumes: System clock of 10 MHz
// Notes: Times are kept in their own unit, cycle counts derived from them
package eesf_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam logic [3:0] CODE_MEMORY = 4'ha;
  localparam logic [3:0] CODE_PROTECT = 4'h6;
  localparam int OUT_DELAY_NS = 300;
  localparam int OUT_DELAY_CYC = (OUT_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam int WRITE_CYCLE_MS = 5;
  localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_MS * 1000000) / CLK_NS;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES = 256;
  localparam int LINK_DIV = 40;
  localparam int FIFO_DEPTH = 8;
  localparam logic [7:0] MEM_RESET = 8'hff;
endpackage

//--- verilog/eesf_link_if.sv
// Purpose: Open-drain two-wire link between master and slave
// Assumes: Pull-ups on both lines
// Notes: Data line level resolved from the two enables, clock line from the master enable alone
`timescale 1ns/1ps
interface eesf_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
    input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface

//--- verilog/eesf_fifo.sv
// Purpose: Small synchronous FIFO with valid and ready on both sides
// Assumes: One clock
// Notes: Depth is a power of two
`timescale 1ns/1ps
module eesf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic push;
  logic pop;
  assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule

//--- verilog/eesf_slave.sv
// Purpose: Slave end: framing, control byte decode, acknowledge, memory
// Assumes: Link lines sampled by clk_sys through two flip-flops
// Notes: Written data queue through a FIFO into the page buffer
`timescale 1ns/1ps
module eesf_slave
  import eesf_pkg::*;
#(
  parameter int WRITE_CYCLES = WRITE_CYCLE_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  eesf_link_if.slave link,
  input wire logic chip_select_pin_high,
  input wire logic chip_select_pin_mid,
  input wire logic chip_select_pin_low,
  output logic busy,
  output logic protect_set
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CTRL = 3'b001,
    ST_ADDR = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_RACK = 3'b101,
    ST_PROT = 3'b110
  } eesf_state_type;
  eesf_state_type state;
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [3:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] byte_in;
  logic [7:0] pointer;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] page [PAGE_BYTES];
  logic [3:0] page_wr;
  logic [4:0] page_cnt;
  logic [7:0] page_base;
  logic [3:0] page_rd;
  logic [31:0] wc_cnt;
  logic ack_bit;
  logic ack_drive;
  logic [7:0] tx_byte;
  logic sda_want;
  logic sda_pend;
  logic [7:0] hold_cnt;
  logic fifo_valid;
  logic fifo_ready;
  logic [7:0] fifo_data;
  logic q_valid;
  logic q_ready;
  logic [7:0] q_data;
  logic byte_done;
  logic prog_go;
  logic [2:0] cs_meta;
  logic [2:0] cs_pins;
  logic protect_was;
  logic protect_set_write;
  // ----------------------------------------
  // Line sampling and conditions
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      cs_meta <= 3'h0;
      cs_pins <= 3'h0;
    end else begin
      scl_sync <= {scl_sync[0], link.scl};
      sda_sync <= {sda_sync[0], link.sda};
      scl_d <= scl_sync[1];
      sda_d <= sda_sync[1];
      cs_meta <= {chip_select_pin_high, chip_select_pin_mid, chip_select_pin_low};
      cs_pins <= cs_meta;
    end
  end
  assign scl_rise = scl_sync[1] && !scl_d;
  assign scl_fall = !scl_sync[1] && scl_d;
  assign start_seen = scl_sync[1] && scl_d && sda_d && !sda_sync[1];
  assign stop_seen = scl_sync[1] && scl_d && !sda_d && sda_sync[1];
  assign byte_done = scl_rise && bit_cnt == 4'h7;
  // ----------------------------------------
  // Bit counter and shifter
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bit_cnt <= 4'h0;
      shift_in <= 8'h00;
    end else if (start_seen || stop_seen) begin
      // Fall after Start wraps to bit 0, so it opens the first bit
      bit_cnt <= start_seen ? 4'hf : 4'h0;
    end else if (scl_rise) begin
      shift_in <= {shift_in[6:0], sda_sync[1]};
    end else if (scl_fall && state != ST_IDLE) begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
    end
  end
  assign byte_in = {shift_in[6:0], sda_sync[1]};
  // ----------------------------------------
  // Protocol state
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      ack_bit <= 1'b0;
      pointer <= 8'h00;
      protect_set <= 1'b0;
      page_cnt <= 5'h0;
      page_wr <= 4'h0;
      page_base <= 8'h00;
      prog_go <= 1'b0;
    end else begin
      prog_go <= 1'b0;
      if (start_seen) begin
        state <= ST_CTRL;
        ack_bit <= 1'b0;
      end else if (stop_seen) begin
        if ((state == ST_WDATA && page_cnt != 5'h0) || state == ST_PROT) begin
          prog_go <= 1'b1;
        end
        if (state == ST_PROT) begin
          protect_set <= 1'b1;
        end
        state <= ST_IDLE;
        ack_bit <= 1'b0;
      end else if (byte_done) begin
        ack_bit <= 1'b0;
        case (state)
          ST_CTRL: begin
            if (busy || byte_in[3:1] != cs_pins) begin
              state <= ST_IDLE;
            end else if (byte_in[7:4] == CODE_MEMORY) begin
              ack_bit <= 1'b1;
              state <= byte_in[0] ? ST_RDATA : ST_ADDR;
              page_cnt <= 5'h0;
            end else if (byte_in[7:4] == CODE_PROTECT && !byte_in[0]
                && !protect_set) begin
              ack_bit <= 1'b1;
              state <= ST_PROT;
            end else begin
              state <= ST_IDLE;
            end
          end
          ST_ADDR: begin
            pointer <= byte_in;
            page_base <= {byte_in[7:4], 4'h0};
            page_wr <= byte_in[3:0];
            ack_bit <= 1'b1;
            state <= ST_WDATA;
          end
          ST_WDATA, ST_PROT: begin
            ack_bit <= fifo_ready;
            if (state == ST_WDATA && fifo_ready) begin
              pointer <= {pointer[7:4], pointer[3:0] + 4'h1};
              if (page_cnt != 5'(PAGE_BYTES)) begin
                page_cnt <= page_cnt + 5'h1;
              end
            end
          end
          ST_RDATA: begin
            pointer <= pointer + 8'h1;
            state <= ST_RACK;
          end
          default: state <= ST_IDLE;
        endcase
      end else if (state == ST_RACK && scl_rise && bit_cnt == 4'h8) begin
        state <= sda_sync[1] ? ST_IDLE : ST_RDATA;
      end
    end
  end
  assign fifo_valid = byte_done && state == ST_WDATA;
  assign fifo_data = byte_in;
  eesf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(fifo_valid),
    .in_ready(fifo_ready),
    .in_data(fifo_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );
  // ----------------------------------------
  // Page buffer, programming timer, memory
  // ----------------------------------------
  // Drain stalls during programming so back-pressure reaches the link
  assign q_ready = !busy;
  always_ff @(posedge clk_sys) begin
    if (q_valid && q_ready) begin
      page[page_rd] <= q_data;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      page_rd <= 4'h0;
    end else if (start_seen) begin
      page_rd <= page_wr;
    end else if (state == ST_ADDR && byte_done) begin
      page_rd <= byte_in[3:0];
    end else if (q_valid && q_ready) begin
      page_rd <= page_rd + 4'h1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wc_cnt <= 32'h0;
      busy <= 1'b0;
    end else if (prog_go) begin
      wc_cnt <= 32'(WRITE_CYCLES);
      busy <= 1'b1;
    end else if (busy) begin
      wc_cnt <= wc_cnt - 32'h1;
      busy <= wc_cnt != 32'h1;
    end
  end
  // Page lands when the cycle ends; only slots received since the address
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < MEM_BYTES; i++) begin
        mem[i] <= MEM_RESET;
      end
    end else if (wc_cnt == 32'h1 && busy && !protect_set_write) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (4'(i) - page_wr < page_cnt[3:0] || page_cnt == 5'(PAGE_BYTES)) begin
          mem[page_base + 8'(i)] <= page[i];
        end
      end
    end
  end
  assign protect_set_write = (page_base < 8'h80) && protect_was;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      protect_was <= 1'b0;
    end else if (prog_go) begin
      protect_was <= protect_set || state == ST_PROT;
    end
  end
  // ----------------------------------------
  // Data line drive with output hold
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tx_byte <= 8'hff;
    end else if (scl_fall && bit_cnt == 4'h8 && state == ST_RDATA) begin
      tx_byte <= mem[pointer];
    end else if (state == ST_CTRL) begin
      tx_byte <= mem[pointer];
    end else if (scl_fall && state == ST_RDATA && bit_cnt != 4'h8) begin
      tx_byte <= {tx_byte[6:0], 1'b1};
    end
  end
  always_comb begin
    sda_pend = 1'b1;
    ack_drive = ack_bit && bit_cnt == 4'h8;
    if (ack_drive) begin
      sda_pend = 1'b0;
    end else if (state == ST_RDATA && bit_cnt != 4'h8) begin
      sda_pend = tx_byte[7];
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hold_cnt <= 8'h0;
      sda_want <= 1'b1;
    end else if (scl_fall) begin
      hold_cnt <= 8'(OUT_DELAY_CYC);
    end else if (hold_cnt != 8'h0) begin
      hold_cnt <= hold_cnt - 8'h1;
    end else if (!scl_sync[1]) begin
      sda_want <= sda_pend;
    end else if (state == ST_IDLE || state == ST_CTRL) begin
      sda_want <= 1'b1;
    end
  end
  assign link.sda_s_o = 1'b0;
  assign link.sda_s_oe = !sda_want;
endmodule

//--- verilog/eesf_master.sv
// Purpose: Master end: divided link clock, Start, bytes, acknowledge, Stop
// Assumes: One byte command at a time from the user side
// Notes: Link clock is clk_sys divided by LINK_DIV
`timescale 1ns/1ps
module eesf_master
  import eesf_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  eesf_link_if.master link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_nack,
  input wire logic [7:0] cmd_data,
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_ack
);
  typedef enum logic [2:0] {
    MS_IDLE = 3'b000,
    MS_START = 3'b001,
    MS_BITS = 3'b010,
    MS_STOP = 3'b011,
    MS_DONE = 3'b100
  } eesf_mstate_type;
  eesf_mstate_type state;
  logic [7:0] tick;
  logic [1:0] phase;
  logic [3:0] bit_cnt;
  logic [8:0] shift;
  // Nine samples kept: eight data bits, then the acknowledge
  logic [8:0] rx;
  logic scl_out;
  logic sda_out;
  logic stop_after;
  logic rd;
  logic [1:0] sda_sync;
  logic step;
  assign step = tick == 8'(LINK_DIV / 4 - 1);
  assign cmd_ready = state == MS_IDLE;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sda_sync <= 2'h3;
    end else begin
      sda_sync <= {sda_sync[0], link.sda};
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick <= 8'h0;
    end else begin
      tick <= (step || state == MS_IDLE) ? 8'h0 : tick + 8'h1;
    end
  end
  // Quarter phases: 0 low-set, 1 rise, 2 sample, 3 fall
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state <= MS_IDLE;
      phase <= 2'h0;
      bit_cnt <= 4'h0;
      shift <= 9'h1ff;
      rx <= 9'h000;
      scl_out <= 1'b1;
      sda_out <= 1'b1;
      stop_after <= 1'b0;
      rd <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      rsp_ack <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      case (state)
        MS_IDLE: begin
          if (cmd_valid) begin
            rd <= cmd_read;
            stop_after <= cmd_stop;
            shift <= cmd_read ? {8'hff, cmd_nack} : {cmd_data, 1'b1};
            bit_cnt <= 4'h0;
            phase <= 2'h0;
            state <= cmd_start ? MS_START : MS_BITS;
          end
        end
        MS_START: if (step) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              sda_out <= 1'b1;
            end
            2'h1: begin
              scl_out <= 1'b1;
            end
            2'h2: begin
              sda_out <= 1'b0;
            end
            default: begin
              scl_out <= 1'b0;
              state <= MS_BITS;
            end
          endcase
        end
        MS_BITS: if (step) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              sda_out <= shift[8];
            end
            2'h1: begin
              scl_out <= 1'b1;
            end
            2'h2: begin
              rx <= {rx[7:0], sda_sync[1]};
            end
            default: begin
              scl_out <= 1'b0;
              shift <= {shift[7:0], 1'b1};
              bit_cnt <= bit_cnt + 4'h1;
              if (bit_cnt == 4'h8) begin
                rsp_valid <= 1'b1;
                rsp_data <= rd ? rx[8:1] : cmd_data;
                rsp_ack <= !rx[0];
                state <= stop_after ? MS_STOP : MS_DONE;
              end
            end
          endcase
        end
        MS_STOP: if (step) begin
          phase <= phase + 2'h1;
          case (phase)
            2'h0: begin
              sda_out <= 1'b0;
            end
            2'h1: begin
              scl_out <= 1'b1;
            end
            2'h2: begin
              sda_out <= 1'b1;
            end
            default: begin
              state <= MS_IDLE;
            end
          endcase
        end
        MS_DONE: begin
          sda_out <= 1'b1;
          state <= MS_IDLE;
        end
        default: state <= MS_IDLE;
      endcase
    end
  end
  assign link.scl_o = 1'b0;
  assign link.scl_oe = !scl_out;
  assign link.sda_m_o = 1'b0;
  assign link.sda_m_oe = !sda_out;
endmodule

//--- test/eesf_sva.sv
// Purpose: Wire checks on the two-wire link between master and slave
// Assumes: Levels resolved in the interface, all sampled by clk_sys
// Notes: Status outputs of the slave watched beside the wires
`timescale 1ns/1ps
module eesf_sva #(
  parameter int WRITE_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe,
  input wire logic busy,
  input wire logic protect_set
);
  // ----------------------------------------
  // Line history and counters
  // ----------------------------------------
  logic scl_q;
  logic sda_q;
  int rise_cnt;
  int busy_cnt;
  wire start = scl && scl_q && sda_q && !sda;
  wire stop = scl && scl_q && !sda_q && sda;
  wire rise = scl && !scl_q;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  // Cleared on both framing events, so a restart sees only its own bits
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rise_cnt <= 0;
    end else if (start || stop) begin
      rise_cnt <= 0;
    end else if (rise) begin
      rise_cnt <= rise_cnt + 1;
    end
  end
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst || !busy) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_slave_data_hold:
  assert property ($changed(sda_s_oe) |-> !scl && !scl_q) else $error("slave moved data in high");
  chk_out_change_delay:
  assert property ($fell(scl) |=> $stable(sda_s_oe) [*2]) else $error("slave output too early");
  chk_ack_through_high:
  assert property (sda_s_oe && $rose(scl) |-> sda_s_oe [*8]) else $error("slave low not held");
  chk_busy_no_ack:
  assert property (busy |-> !sda_s_oe) else $error("slave drove line while busy");
  chk_write_time_bound:
  assert property (busy_cnt <= WRITE_CYCLES) else $error("write cycle too long");
  chk_start_restarts_rx:
  assert property (start |=> !sda_s_oe [*8]) else $error("slave drove line after start");
  chk_stop_releases:
  assert property (stop |=> !sda_s_oe [*8]) else $error("slave drove line after stop");
  chk_nine_clocks:
  assert property (stop |-> rise_cnt % 9 == 1) else $error("clock count not nine per byte");
  chk_frame_start:
  assert property (start |-> rise_cnt == 0 || rise_cnt % 9 == 1) else $error("start off boundary");
  chk_protect_sticky:
  assert property ($past(protect_set) |-> protect_set) else $error("protect flag cleared");
  cover property (start);
  cover property ($rose(busy));
  cover property ($rose(protect_set));
  cover property (sda_s_oe && $rose(scl));
endmodule

//--- test/eesf_test.sv
// Purpose: Master and slave ends joined, driven from the master user side
// Assumes: Strap pins random but static after reset
// Notes: Write cycle shortened so polling fits inside it
`timescale 1ns/1ps
module eesf_test
  import eesf_pkg::*;
;
  localparam int WT = 2000;
  typedef struct packed {logic ack; logic [7:0] data;} eesf_exp_type;
  logic clk_sys, rst, cmd_valid, cmd_ready, cmd_start, cmd_stop, cmd_read, cmd_nack;
  logic rsp_valid, rsp_ack, busy, protect_set;
  logic [7:0] cmd_data, rsp_data, base;
  logic [7:0] mem [0:15];
  logic [2:0] cs;
  eesf_exp_type exp_q[$];
  eesf_exp_type cur;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  eesf_link_if i_eesf_link_if ();
  eesf_master i_eesf_master (.clk_sys(clk_sys), .rst(rst), .link(i_eesf_link_if.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop),
    .cmd_read(cmd_read), .cmd_nack(cmd_nack), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_ack(rsp_ack));
  eesf_slave #(.WRITE_CYCLES(WT)) i_eesf_slave (.clk_sys(clk_sys), .rst(rst),
    .link(i_eesf_link_if.slave), .chip_select_pin_high(cs[2]), .chip_select_pin_mid(cs[1]),
    .chip_select_pin_low(cs[0]), .busy(busy), .protect_set(protect_set));
  eesf_sva #(.WRITE_CYCLES(WT)) i_eesf_sva (.clk_sys(clk_sys), .rst(rst),
    .scl(i_eesf_link_if.scl), .sda(i_eesf_link_if.sda), .sda_s_oe(i_eesf_link_if.sda_s_oe),
    .busy(busy), .protect_set(protect_set));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  // ----------------------------------------
  // Compare, drive and verdict tasks
  // ----------------------------------------
  task automatic compare_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic compare_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(input logic st, input logic sp, input logic rd, input logic nk,
      input logic [7:0] d, input logic ea, input logic [7:0] ed);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    exp_q.push_back('{ea, ed});
    cmd_valid <= 1'b1;
    cmd_start <= st;
    cmd_stop <= sp;
    cmd_read <= rd;
    cmd_nack <= nk;
    cmd_data <= d;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    compare_bit("response_seen", 1'b1, n < 5000);
  endtask
  task automatic wr(input logic st, input logic sp, input logic [7:0] d, input logic ea);
    send(st, sp, 1'b0, 1'b0, d, ea, d);
  endtask
  task automatic wait_busy(input logic lvl, input int lim);
    int n;
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        compare_bit("rsp_expected", 1'b0, 1'b1);
      end else begin
        cur = exp_q.pop_front();
        compare_bit("rsp_ack", cur.ack, rsp_ack);
        compare_byte("rsp_data", cur.data, rsp_data);
      end
    end
  end
  // Hang guard, about three times the expected run
  initial begin
    repeat (80000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    int t0;
    logic [7:0] db;
    rst = 1'b1;
    {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack} = 5'h00;
    cmd_data = 8'h00;
    cs = 3'h0;
    void'($urandom(32'h1ef97490));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    cs <= 3'($urandom());
    @(posedge clk_sys);
    wr(1'b1, 1'b1, {CODE_MEMORY, cs ^ 3'h1, 1'b0}, 1'b0);
    for (int c = 0; c < 16; c++) begin
      if (4'(c) != CODE_MEMORY && 4'(c) != CODE_PROTECT) begin
        wr(1'b1, 1'b1, {4'(c), cs, 1'($urandom())}, 1'b0);
      end
    end
    wr(1'b1, 1'b1, {CODE_PROTECT, cs, 1'b1}, 1'b0);
    // Page write of 18 bytes: first two overwritten by the wrap
    base = {4'($urandom()), 4'h0};
    wr(1'b1, 1'b0, {CODE_MEMORY, cs, 1'b0}, 1'b1);
    wr(1'b0, 1'b0, base, 1'b1);
    for (int i = 0; i < 18; i++) begin
      db = 8'($urandom());
      mem[i % 16] = db;
      wr(1'b0, i == 17, db, 1'b1);
    end
    wait_busy(1'b1, 300);
    compare_bit("busy", 1'b1, busy);
    t0 = cyc;
    wr(1'b1, 1'b1, {CODE_MEMORY, cs, 1'b0}, 1'b0);
    wait_busy(1'b0, WT + 100);
    compare_bit("write_time_ok", 1'b1, (cyc - t0) <= WT);
    // Random read with restart, last byte refused by the master
    wr(1'b1, 1'b0, {CODE_MEMORY, cs, 1'b0}, 1'b1);
    wr(1'b0, 1'b0, base, 1'b1);
    wr(1'b1, 1'b0, {CODE_MEMORY, cs, 1'b1}, 1'b1);
    for (int i = 0; i < 16; i++) begin
      send(1'b0, i == 15, 1'b1, i == 15, 8'hff, i != 15, mem[i]);
    end
    // Protect register write, then its code is refused
    wr(1'b1, 1'b0, {CODE_PROTECT, cs, 1'b0}, 1'b1);
    wr(1'b0, 1'b0, 8'($urandom()), 1'b1);
    wr(1'b0, 1'b1, 8'($urandom()), 1'b1);
    wait_busy(1'b1, 300);
    wait_busy(1'b0, WT + 100);
    compare_bit("protect_set", 1'b1, protect_set);
    wr(1'b1, 1'b1, {CODE_PROTECT, cs, 1'b0}, 1'b0);
    give_verdict();
  end
endmodule
